/* File: core/can_xcvr_pkg.sv */
// shared types, codes and timing constants for the can channel mode and wake control
package can_xcvr_pkg;

	// system operating modes as seen by the channel
	typedef enum logic [2:0] {
		SYS_NORMAL,
		SYS_INIT,
		SYS_STOP,
		SYS_SLEEP,
		SYS_RESTART,
		SYS_FAILSAFE
	} sys_mode_e;

	// channel mode field codes; only the wake-capable code is fixed, the others are ours
	localparam logic [1:0] CHM_OFF = 2'h0;
	localparam logic [1:0] CHM_WAKE = 2'h1;
	localparam logic [1:0] CHM_RXONLY = 2'h2;
	localparam logic [1:0] CHM_NORMAL = 2'h3;
	localparam logic [1:0] CHM_RST = CHM_OFF;

	// wake pattern detector states
	typedef enum logic [1:0] {
		W_IDLE,
		W_DOM1,
		W_REC,
		W_DOM2
	} wake_st_e;

	// one wake event record handed to the host side
	typedef struct packed {
		sys_mode_e sys_mode;
		logic wd_forced;
		logic restart;
	} wake_evt_s;

	// timing, clock is 125 MHz
	localparam int CLK_NS = 8;
	localparam int CNT_W = 20;
	localparam int ENABLE_DELAY_NS = 8000;
	localparam int WAKE_DOM_FILTER_NS = 1000;
	localparam int WAKE_REC_LIMIT_NS = 6000;
	localparam int TX_DOM_TIMEOUT_NS = 4500000;
	localparam int BUS_DOM_TIMEOUT_NS = 4500000;
	// least times round up, the recessive limit (a longest time) rounds down
	localparam int ENABLE_DELAY_CYC = (ENABLE_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_DOM_FILTER_CYC = (WAKE_DOM_FILTER_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_REC_LIMIT_CYC = WAKE_REC_LIMIT_NS / CLK_NS;
	localparam int TX_DOM_TIMEOUT_CYC = (TX_DOM_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUS_DOM_TIMEOUT_CYC = (BUS_DOM_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;

endpackage : can_xcvr_pkg

/* File: core/can_transceiver_mode_wake_ctrl.sv */
// can transceiver channel: modes, enable delay, wake detection, time-outs, undervoltage
// Functional notes
// - start in off mode, bus high impedance
// - off mode ignores bus wake activity
// - normal only in system normal or init+dev
// - normal: drive follows tx, rx shows bus
// - early dominant ignored until recessive after delay
// - slope control on, bypass bit disables it
// - receive-only: driver off, only normal/stop
// - wake mode in stop/sleep/restart/normal, forced failsafe
// - wake pattern drives rx low until mode change
// - pattern: two long dominants, short recessive gap
// - after wake field reads 01, channel disarmed
// - mode toggle rearms, flag clear not needed
// - entering stop, sleep, failsafe rearms detection
// - wake in stop/normal: interrupt, status, no move
// - stop wake forces watchdog when configured
// - sleep wake: restart, rx low, no interrupt
// - tx dominant time-out: driver off, fail flag
// - time-out cleared: driver back, config kept
// - bus dominant time-out sets fail flag
// - undervoltage in normal/rxonly: flag, driver off
// - supply recovered: back to normal, config kept
`timescale 1ns/100ps
`default_nettype none
module can_transceiver_mode_wake_ctrl
	import can_xcvr_pkg::*;
#(
	parameter int EN_CYC = ENABLE_DELAY_CYC, // enable delay in cycles
	parameter int WK1_CYC = WAKE_DOM_FILTER_CYC, // wake dominant filter
	parameter int WK2_CYC = WAKE_REC_LIMIT_CYC, // wake recessive limit
	parameter int TXTO_CYC = TX_DOM_TIMEOUT_CYC, // tx dominant time-out
	parameter int BUSTO_CYC = BUS_DOM_TIMEOUT_CYC // bus dominant time-out
) (
	input wire logic ref_clk, // core clock
	input wire logic srst, // synchronous reset, high
	input wire sys_mode_e sys_mode, // current system mode
	input wire logic dev_mode_active, // development mode strap
	input wire logic mode_wr, // software mode write strobe
	input wire logic [1:0] mode_req, // requested channel mode code
	input wire logic slope_bypass_cfg, // slope-bypass bit
	input wire logic watchdog_on_bus_wake, // force watchdog on stop wake
	input wire logic watchdog_enabled, // watchdog currently on
	input wire logic tx_data_in, // controller tx, 0 = dominant
	input wire logic bus_rx_in, // decoded bus level, 0 = dominant
	input wire logic supply_uv_in, // transceiver supply below threshold
	input wire logic wake_flag_clr, // clears wake flag and status
	input wire logic fail_flag_clr, // clears channel fail flag
	input wire logic uv_flag_clr, // clears undervoltage flag
	input wire logic wake_evt_ready, // host takes a wake record
	output logic [1:0] channel_mode_field, // mode as software reads it
	output logic bus_hiz, // bus pins high impedance
	output logic bus_drv_en, // driver stage enabled
	output logic bus_drive_dom, // drive bus dominant
	output logic slope_ctrl_bypass, // slope control bypassed
	output logic rx_data_out, // receive data to controller
	output logic bus_wake_flag, // sticky bus wake flag
	output logic fail_flag, // sticky channel fail flag
	output logic supply_undervolt_flag, // sticky undervoltage flag
	output logic interrupt_out_n, // interrupt, active low
	output logic wake_status_a, // wake status bit, register a
	output logic wake_status_b, // wake status bit, register b
	output logic watchdog_force_en, // request to switch watchdog on
	output logic restart_req, // one-cycle request: system to restart
	output logic wake_evt_valid, // wake record available
	output wake_evt_s wake_evt_data // oldest wake record
);

	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	// ---------- mode and flag state ----------
	logic [1:0] chm_q, chm_d;
	logic armed_q, armed_d, woken_q, woken_d;
	logic wflag_q, wflag_d, fail_q, fail_d, uvf_q, uvf_d;
	logic irq_n_q, irq_n_d, wsa_q, wsa_d, wsb_q, wsb_d, wdf_q, wdf_d;
	logic rreq_q, rreq_d;
	sys_mode_e sys_prev_q, sys_prev_d;
	logic allow;
	logic wake_hit, txto_hit, busto_hit;
	logic pend_q, pend_d;

	// software mode requests are filtered by the system mode; illegal writes are dropped
	always_comb begin
		chm_d = chm_q;
		armed_d = armed_q;
		woken_d = woken_q;
		wflag_d = wflag_q;
		fail_d = fail_q;
		uvf_d = uvf_q;
		irq_n_d = irq_n_q;
		wsa_d = wsa_q;
		wsb_d = wsb_q;
		wdf_d = wdf_q;
		rreq_d = 1'b0;
		sys_prev_d = sys_mode;
		case (mode_req)
			CHM_OFF: allow = 1'b1;
			CHM_NORMAL: allow = (sys_mode == SYS_NORMAL) ||
				(sys_mode == SYS_INIT && dev_mode_active);
			CHM_RXONLY: allow = (sys_mode == SYS_NORMAL) || (sys_mode == SYS_STOP);
			default: allow = (sys_mode == SYS_STOP) || (sys_mode == SYS_SLEEP) ||
				(sys_mode == SYS_RESTART) || (sys_mode == SYS_NORMAL);
		endcase
		if (mode_wr && allow) begin
			chm_d = mode_req;
		end
		if (sys_mode == SYS_FAILSAFE) begin
			chm_d = CHM_WAKE;
		end
		// any other mode rearms, so toggling through it is enough
		if (chm_d != CHM_WAKE) begin
			armed_d = 1'b1;
			woken_d = 1'b0;
		end
		if (sys_mode != sys_prev_q && (sys_mode == SYS_STOP || sys_mode == SYS_SLEEP ||
			sys_mode == SYS_FAILSAFE)) begin
			armed_d = 1'b1;
			woken_d = 1'b0;
		end
		// clears first so that a same-cycle event wins
		if (wake_flag_clr) begin
			wflag_d = 1'b0;
			wsa_d = 1'b0;
			wsb_d = 1'b0;
			irq_n_d = 1'b1;
		end
		if (fail_flag_clr) begin
			fail_d = 1'b0;
		end
		if (uv_flag_clr) begin
			uvf_d = 1'b0;
		end
		if (watchdog_enabled) begin
			wdf_d = 1'b0;
		end
		if (wake_hit) begin
			woken_d = 1'b1;
			armed_d = 1'b0;
			wflag_d = 1'b1;
			wsa_d = 1'b1;
			wsb_d = 1'b1;
			case (sys_mode)
				SYS_NORMAL, SYS_STOP: begin
					irq_n_d = 1'b0;
					if (sys_mode == SYS_STOP && !watchdog_enabled && watchdog_on_bus_wake) begin
						wdf_d = 1'b1;
					end
				end
				SYS_SLEEP, SYS_FAILSAFE: rreq_d = 1'b1;
				default: ;
			endcase
		end
		if (txto_hit || busto_hit) begin
			fail_d = 1'b1;
		end
		if ((chm_q == CHM_NORMAL || chm_q == CHM_RXONLY) && supply_uv_in) begin
			uvf_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			chm_q <= CHM_RST;
			armed_q <= 1'b1;
			woken_q <= 1'b0;
			wflag_q <= 1'b0;
			fail_q <= 1'b0;
			uvf_q <= 1'b0;
			irq_n_q <= 1'b1;
			wsa_q <= 1'b0;
			wsb_q <= 1'b0;
			wdf_q <= 1'b0;
			rreq_q <= 1'b0;
			sys_prev_q <= SYS_NORMAL;
		end else begin
			chm_q <= chm_d;
			armed_q <= armed_d;
			woken_q <= woken_d;
			wflag_q <= wflag_d;
			fail_q <= fail_d;
			uvf_q <= uvf_d;
			irq_n_q <= irq_n_d;
			wsa_q <= wsa_d;
			wsb_q <= wsb_d;
			wdf_q <= wdf_d;
			rreq_q <= rreq_d;
			sys_prev_q <= sys_prev_d;
		end
	end

	// ---------- timers, wake detector and pin drive ----------
	logic [CNT_W-1:0] enc_q, enc_d, txc_q, txc_d, bc_q, bc_d, wc_q, wc_d;
	logic endone_q, endone_d, txarm_q, txarm_d, txto_q, txto_d, busto_q, busto_d;
	logic uv_q, uv_d, drven_q, drven_d, dom_q, dom_d, hiz_q, hiz_d;
	logic slope_q, slope_d, rx_q, rx_d;
	wake_st_e ws_q, ws_d;
	logic in_norm;

	always_comb begin
		in_norm = (chm_q == CHM_NORMAL);
		enc_d = enc_q;
		endone_d = endone_q;
		txarm_d = txarm_q;
		wc_d = wc_q;
		ws_d = ws_q;
		wake_hit = 1'b0;
		// enable delay restarts every time normal mode is entered
		if (!in_norm) begin
			enc_d = '0;
			endone_d = 1'b0;
			txarm_d = 1'b0;
		end else begin
			if (!endone_q) begin
				enc_d = enc_q + 1'b1;
				endone_d = (enc_q == CNT_W'(EN_CYC - 1));
			end
			// a dominant held across the delay is never sent; it must go recessive first
			if (endone_q && tx_data_in) begin
				txarm_d = 1'b1;
			end
		end
		// tx dominant time-out clears when tx is released
		txc_d = (in_norm && !tx_data_in && txc_q != CNT_MAX) ? txc_q + 1'b1 : txc_q;
		if (!in_norm || tx_data_in) txc_d = '0;
		txto_d = in_norm && !tx_data_in && (txto_q || txc_q >= CNT_W'(TXTO_CYC));
		txto_hit = txto_d && !txto_q;
		// bus clamp is watched in every mode and never touches the mode field
		bc_d = (!bus_rx_in && bc_q != CNT_MAX) ? bc_q + 1'b1 : bc_q;
		if (bus_rx_in) bc_d = '0;
		busto_d = !bus_rx_in && (busto_q || bc_q >= CNT_W'(BUSTO_CYC));
		busto_hit = busto_d && !busto_q;
		uv_d = (in_norm || chm_q == CHM_RXONLY) && supply_uv_in;
		// wake pattern detector, idle unless armed in wake mode with no parked record waiting
		if (chm_q != CHM_WAKE || !armed_q || pend_q) begin
			ws_d = W_IDLE;
			wc_d = '0;
		end else begin
			case (ws_q)
				W_IDLE: begin
					wc_d = CNT_W'(1);
					if (!bus_rx_in) ws_d = W_DOM1;
				end
				W_DOM1: begin
					if (!bus_rx_in) begin
						wc_d = (wc_q != CNT_MAX) ? wc_q + 1'b1 : wc_q;
					end else begin
						wc_d = CNT_W'(1);
						ws_d = (wc_q > CNT_W'(WK1_CYC)) ? W_REC : W_IDLE;
					end
				end
				W_REC: begin
					if (bus_rx_in) begin
						wc_d = wc_q + 1'b1;
						if (wc_q >= CNT_W'(WK2_CYC - 1)) ws_d = W_IDLE;
					end else begin
						wc_d = CNT_W'(1);
						ws_d = W_DOM2;
					end
				end
				default: begin
					wc_d = wc_q + 1'b1;
					if (bus_rx_in) begin
						ws_d = W_IDLE;
					end else if (wc_q >= CNT_W'(WK1_CYC)) begin
						wake_hit = 1'b1;
						ws_d = W_IDLE;
					end
				end
			endcase
		end
		drven_d = in_norm && !txto_q && !uv_q;
		dom_d = drven_d && txarm_q && !tx_data_in;
		hiz_d = (chm_q == CHM_OFF);
		slope_d = slope_bypass_cfg;
		case (chm_q)
			CHM_NORMAL, CHM_RXONLY: rx_d = bus_rx_in;
			CHM_WAKE: rx_d = !woken_q;
			default: rx_d = 1'b1;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			enc_q <= '0;
			endone_q <= 1'b0;
			txarm_q <= 1'b0;
			txc_q <= '0;
			txto_q <= 1'b0;
			bc_q <= '0;
			busto_q <= 1'b0;
			uv_q <= 1'b0;
			wc_q <= '0;
			ws_q <= W_IDLE;
			drven_q <= 1'b0;
			dom_q <= 1'b0;
			hiz_q <= 1'b1;
			slope_q <= 1'b0;
			rx_q <= 1'b1;
		end else begin
			enc_q <= enc_d;
			endone_q <= endone_d;
			txarm_q <= txarm_d;
			txc_q <= txc_d;
			txto_q <= txto_d;
			bc_q <= bc_d;
			busto_q <= busto_d;
			uv_q <= uv_d;
			wc_q <= wc_d;
			ws_q <= ws_d;
			drven_q <= drven_d;
			dom_q <= dom_d;
			hiz_q <= hiz_d;
			slope_q <= slope_d;
			rx_q <= rx_d;
		end
	end

	// ---------- two-entry wake record buffer; entry 0 is always the head ----------
	wake_evt_s buf_q [2];
	wake_evt_s buf_d [2];
	logic [1:0] vld_q, vld_d;
	wake_evt_s new_evt;
	wake_evt_s pend_evt_q, pend_evt_d; // record parked while both entries are full
	logic push, pop;

	// a full buffer parks the record in pend and holds the detector idle
	always_comb begin
		new_evt.sys_mode = sys_mode;
		new_evt.wd_forced = wdf_d;
		new_evt.restart = rreq_d;
		pop = vld_q[0] && wake_evt_ready;
		push = (wake_hit || pend_q) && !(vld_q[1] && !pop);
		pend_d = (wake_hit || pend_q) && !push;
		// own register, so a parked record never overwrites a valid entry
		pend_evt_d = wake_hit ? new_evt : pend_evt_q;
		buf_d[0] = pop ? buf_q[1] : buf_q[0];
		buf_d[1] = buf_q[1];
		vld_d[0] = pop ? vld_q[1] : vld_q[0];
		vld_d[1] = pop ? 1'b0 : vld_q[1];
		if (push) begin
			if (!vld_d[0]) begin
				buf_d[0] = pend_q ? pend_evt_q : new_evt;
				vld_d[0] = 1'b1;
			end else begin
				buf_d[1] = pend_q ? pend_evt_q : new_evt;
				vld_d[1] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			vld_q <= 2'h0;
			pend_q <= 1'b0;
			pend_evt_q <= '0;
		end else begin
			buf_q[0] <= buf_d[0];
			buf_q[1] <= buf_d[1];
			vld_q <= vld_d;
			pend_q <= pend_d;
			pend_evt_q <= pend_evt_d;
		end
	end

	assign channel_mode_field = chm_q;
	assign bus_hiz = hiz_q;
	assign bus_drv_en = drven_q;
	assign bus_drive_dom = dom_q;
	assign slope_ctrl_bypass = slope_q;
	assign rx_data_out = rx_q;
	assign bus_wake_flag = wflag_q;
	assign fail_flag = fail_q;
	assign supply_undervolt_flag = uvf_q;
	assign interrupt_out_n = irq_n_q;
	assign wake_status_a = wsa_q;
	assign wake_status_b = wsb_q;
	assign watchdog_force_en = wdf_q;
	assign restart_req = rreq_q;
	assign wake_evt_valid = vld_q[0];
	assign wake_evt_data = buf_q[0];

	// ---------- assertions ----------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	AST_OFF_HIZ: assert property (chm_q == CHM_OFF |=> bus_hiz && !bus_drv_en)
		else $error("off mode not high impedance");
	AST_OFF_NO_WAKE: assert property (chm_q != CHM_WAKE |=> ws_q == W_IDLE)
		else $error("wake detector ran outside wake mode");
	AST_NORM_GATE: assert property (mode_wr && mode_req == CHM_NORMAL && sys_mode == SYS_STOP
		|=> chm_q != CHM_NORMAL || $past(chm_q) == CHM_NORMAL)
		else $error("normal mode taken in stop");
	AST_EN_DELAY: assert property ($rose(chm_q == CHM_NORMAL) |-> !bus_drive_dom [*8])
		else $error("dominant driven inside enable delay");
	AST_RXONLY_NODRV: assert property (chm_q == CHM_RXONLY |=> !bus_drv_en)
		else $error("driver on in receive-only");
	AST_WAKE_RX_LOW: assert property (wake_hit ##1 chm_q == CHM_WAKE |=> !rx_data_out)
		else $error("rx not low after wake");
	AST_WAKE_CODE: assert property (wake_hit && !mode_wr |=> channel_mode_field == CHM_WAKE
		&& !armed_q)
		else $error("mode field changed by wake");
	AST_SLEEP_NO_IRQ: assert property (wake_hit && sys_mode == SYS_SLEEP && interrupt_out_n
		|=> interrupt_out_n && restart_req)
		else $error("sleep wake mishandled");
	AST_TXTO_OFF: assert property (txto_q |=> !bus_drv_en)
		else $error("driver on during tx time-out");
	AST_TXTO_FLAG: assert property ($rose(txto_q) |-> fail_flag)
		else $error("tx time-out without fail flag");
	AST_UV_FLAG: assert property (in_norm && supply_uv_in |=> supply_undervolt_flag
		##1 !bus_drv_en)
		else $error("undervoltage not handled");

endmodule : can_transceiver_mode_wake_ctrl
`default_nettype wire

/* File: tb/can_bus_model.sv */
// bus model: wired dominant bus shared by this channel and other nodes
`timescale 1ns/100ps
`default_nettype none
module can_bus_model (
	input wire logic drv_en, // channel driver stage on
	input wire logic drv_dom, // channel drives dominant
	input wire logic other_dom, // another node drives dominant
	output logic rx_level // decoded bus level, 0 = dominant
);
	// dominant wins; with nobody driving, the bias pulls the bus recessive
	assign rx_level = !((drv_en && drv_dom) || other_dom);
endmodule : can_bus_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the can channel mode and wake control
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import can_xcvr_pkg::*;
	// short counts keep the run small; the delay, pattern and time-out waits below are derived from them
	localparam int EN = 10;
	localparam int WK1 = 4;
	localparam int WK2 = 8;
	localparam int TO = 20;
	logic ref_clk = 1'h0, srst = 1'h1, dev = 1'h0, mode_wr = 1'h0, slope_cfg = 1'h0;
	logic wd_cfg = 1'h0, wd_on = 1'h0, tx = 1'h1, uv = 1'h0, ready = 1'h0, other_dom = 1'h0;
	logic wclr = 1'h0, fclr = 1'h0, uclr = 1'h0, bus_rx, last_bus;
	sys_mode_e sys_mode = SYS_NORMAL;
	logic [1:0] mode_req = 2'h0, field;
	logic hiz, drv_en, drv_dom, slope_byp, rx_out, wk_flag, fail, uv_flag, irq_n;
	logic st_a, st_b, wd_force, restart, ev_valid;
	wake_evt_s ev_data;
	int n_fail = 0, checks_done = 0, n_restart = 0;
	logic [31:0] lfsr = 32'hb0d6;
	logic [4:0] exp_q[$]; // wake records the host should see, oldest first

	can_transceiver_mode_wake_ctrl #(.EN_CYC(EN), .WK1_CYC(WK1), .WK2_CYC(WK2),
		.TXTO_CYC(TO), .BUSTO_CYC(TO)) can_transceiver_mode_wake_ctrl_i (
		.ref_clk(ref_clk), .srst(srst), .sys_mode(sys_mode), .dev_mode_active(dev),
		.mode_wr(mode_wr), .mode_req(mode_req), .slope_bypass_cfg(slope_cfg),
		.watchdog_on_bus_wake(wd_cfg), .watchdog_enabled(wd_on), .tx_data_in(tx),
		.bus_rx_in(bus_rx), .supply_uv_in(uv), .wake_flag_clr(wclr), .fail_flag_clr(fclr),
		.uv_flag_clr(uclr), .wake_evt_ready(ready), .channel_mode_field(field),
		.bus_hiz(hiz), .bus_drv_en(drv_en), .bus_drive_dom(drv_dom),
		.slope_ctrl_bypass(slope_byp), .rx_data_out(rx_out), .bus_wake_flag(wk_flag),
		.fail_flag(fail), .supply_undervolt_flag(uv_flag), .interrupt_out_n(irq_n),
		.wake_status_a(st_a), .wake_status_b(st_b), .watchdog_force_en(wd_force),
		.restart_req(restart), .wake_evt_valid(ev_valid), .wake_evt_data(ev_data));

	can_bus_model can_bus_model_i (.drv_en(drv_en), .drv_dom(drv_dom),
		.other_dom(other_dom), .rx_level(bus_rx));

	initial begin
		forever #4 ref_clk = ~ref_clk;
	end

	// restart requests are single-cycle pulses, so count them at every falling edge
	always @(negedge ref_clk) begin
		if (restart === 1'h1) n_restart++;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic seen, input logic exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	task automatic set_mode(input logic [1:0] m);
		mode_req = m;
		mode_wr = 1'h1;
		cyc(1);
		mode_wr = 1'h0;
		cyc(2);
	endtask : set_mode

	task automatic clr_all();
		{wclr, fclr, uclr} = 3'h7;
		cyc(1);
		{wclr, fclr, uclr} = 3'h0;
		cyc(1);
	endtask : clr_all

	// two long dominant phases around a short recessive gap, driven by another node
	task automatic wake_pattern();
		other_dom = 1'h1;
		cyc(WK1 + 3);
		other_dom = 1'h0;
		cyc(WK2 - 5);
		other_dom = 1'h1;
		cyc(WK1 + 3);
		other_dom = 1'h0;
		cyc(4);
	endtask : wake_pattern

	// host accepts records; the buffer must hand them over in order and then run dry
	task automatic drain();
		ready = 1'h1;
		repeat (6) begin
			if (ev_valid === 1'h1 && exp_q.size() > 0) chk(ev_data === exp_q.pop_front(), 1'h1);
			cyc(1);
		end
		ready = 1'h0;
		chk(exp_q.size() == 0 && ev_valid === 1'h0, 1'h1);
	endtask : drain

	initial begin
		#20000;
		n_fail++;
		report_and_stop();
	end

	initial begin
		cyc(8);
		srst = 1'h0;
		cyc(1);
		chk(field === CHM_OFF && hiz === 1'h1 && rx_out === 1'h1, 1'h1);
		chk(irq_n & !wk_flag & !fail & !uv_flag, 1'h1);
		// requests outside their system modes are dropped
		sys_mode = SYS_STOP;
		set_mode(CHM_NORMAL);
		chk(field === CHM_OFF, 1'h1);
		sys_mode = SYS_SLEEP;
		set_mode(CHM_RXONLY);
		chk(field === CHM_OFF, 1'h1);
		sys_mode = SYS_INIT;
		set_mode(CHM_WAKE);
		chk(field === CHM_OFF, 1'h1);
		set_mode(CHM_NORMAL);
		chk(field === CHM_OFF, 1'h1);
		dev = 1'h1;
		set_mode(CHM_NORMAL);
		chk(field === CHM_NORMAL, 1'h1);
		set_mode(CHM_OFF);
		chk(field === CHM_OFF && hiz === 1'h1, 1'h1);
		// off mode ignores a wake pattern, but a clamped bus still flags a fault
		sys_mode = SYS_STOP;
		wake_pattern();
		chk(wk_flag, 1'h0);
		other_dom = 1'h1;
		cyc(TO + 4);
		other_dom = 1'h0;
		cyc(2);
		chk(fail === 1'h1 && field === CHM_OFF, 1'h1);
		clr_all();
		// dominant inside the enable delay is held back
		sys_mode = SYS_NORMAL;
		set_mode(CHM_NORMAL);
		tx = 1'h0;
		repeat (EN - 4) begin
			cyc(1);
			chk(drv_dom, 1'h0);
		end
		tx = 1'h1; // controller returns recessive before sending
		cyc(EN);
		// random traffic: drive follows tx a cycle late, rx follows the bus
		repeat (64) begin
			last_bus = bus_rx;
			lfsr = lfsr_next(lfsr);
			tx = lfsr[0] | lfsr[7];
			slope_cfg = lfsr[3];
			cyc(1);
			chk(drv_dom === !tx && drv_en === 1'h1, 1'h1);
			chk(slope_byp, slope_cfg);
			chk(rx_out, last_bus);
		end
		tx = 1'h1;
		set_mode(CHM_RXONLY);
		tx = 1'h0;
		other_dom = 1'h1;
		cyc(3);
		chk(drv_en === 1'h0 && rx_out === 1'h0, 1'h1);
		tx = 1'h1;
		other_dom = 1'h0;
		// stuck dominant tx times out, then recovers with the config kept
		set_mode(CHM_NORMAL);
		cyc(EN + 2);
		tx = 1'h0;
		cyc(TO + 4);
		chk(drv_en === 1'h0 && fail === 1'h1, 1'h1);
		tx = 1'h1;
		cyc(3);
		chk(drv_en === 1'h1 && field === CHM_NORMAL, 1'h1);
		// undervoltage overlapping a tx time-out: driver back only when both are gone
		uv = 1'h1;
		cyc(3);
		chk(uv_flag === 1'h1 && drv_en === 1'h0, 1'h1);
		tx = 1'h0;
		cyc(TO + 4);
		uv = 1'h0;
		cyc(3);
		chk(drv_en, 1'h0);
		tx = 1'h1;
		cyc(3);
		chk(drv_en === 1'h1 && field === CHM_NORMAL, 1'h1);
		clr_all();
		// wake in stop: interrupt, status, forced watchdog, field stays wake-capable
		sys_mode = SYS_STOP;
		wd_cfg = 1'h1;
		set_mode(CHM_WAKE);
		// a first dominant phase of only the filter time is no wake
		other_dom = 1'h1;
		cyc(WK1);
		other_dom = 1'h0;
		cyc(3);
		other_dom = 1'h1;
		cyc(WK1 + 3);
		other_dom = 1'h0;
		cyc(WK2 + 2);
		chk(wk_flag, 1'h0);
		wake_pattern();
		chk(wk_flag & st_a & st_b & !irq_n & wd_force, 1'h1);
		chk(rx_out, 1'h0);
		chk(field === CHM_WAKE, 1'h1);
		exp_q.push_back({SYS_STOP, 1'h1, 1'h0});
		wd_on = 1'h1;
		clr_all();
		wake_pattern();
		chk(wk_flag === 1'h0 && rx_out === 1'h0 && wd_force === 1'h0 && st_a === 1'h0, 1'h1);
		// entering sleep rearms; a sleep wake asks for restart without interrupt
		sys_mode = SYS_SLEEP;
		cyc(2);
		wake_pattern();
		chk(wk_flag === 1'h1 && irq_n === 1'h1 && n_restart == 1, 1'h1);
		exp_q.push_back({SYS_SLEEP, 1'h0, 1'h1});
		drain();
		// a mode toggle rearms without clearing the wake flag
		sys_mode = SYS_NORMAL;
		set_mode(CHM_OFF);
		chk(rx_out, 1'h1);
		set_mode(CHM_WAKE);
		wake_pattern();
		chk(wk_flag === 1'h1 && irq_n === 1'h0, 1'h1);
		exp_q.push_back({SYS_NORMAL, 1'h0, 1'h0});
		drain();
		set_mode(CHM_OFF);
		sys_mode = SYS_FAILSAFE;
		cyc(2);
		chk(field === CHM_WAKE, 1'h1);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
